// ### logic/adccs_regs.sv
// Converter setup and status register pair with analog control decode
`include "adccs_cfg.svh"
`default_nettype none
module adccs_regs
    import adccs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Decoded register commands from the serial command decoder
    input wire adccs_cmd_t cmd,
    input wire logic data_read,
    // Converter core events
    input wire logic result_done,
    // Register read data and analog control
    output adccs_ctrl_t ctrl,
    output logic [7:0] rdata,
    output logic filter_restart,
    // Open-drain ready pin and serial clock line enables
    output logic ready_pin_out,
    output logic ready_pin_oe,
    output logic scl_oe
);
    logic [7:0] setup_q, setup_d;
    logic flag_q, flag_d;
    logic [7:0] rdata_q, rdata_d;
    logic restart_q, restart_d;
    adccs_ctrl_t ctrl_q, ctrl_d;
    // Pin drive levels held in flops so every output leaves a register
    logic pin_level_q, scl_drive_q;

    function automatic logic [5:0] mux_decode(input adccs_mux_t m);
        case (m)
            ADCCS_IN_0_1: mux_decode = {3'h0, 3'h1}; // RL1
            ADCCS_IN_2_3: mux_decode = {3'h2, 3'h3};
            ADCCS_IN_1_2: mux_decode = {3'h1, 3'h2};
            ADCCS_IN_0_GND: mux_decode = {3'h0, 3'h4};
            ADCCS_IN_1_GND: mux_decode = {3'h1, 3'h4};
            ADCCS_IN_2_GND: mux_decode = {3'h2, 3'h4};
            ADCCS_IN_3_GND: mux_decode = {3'h3, 3'h4};
            ADCCS_IN_MID_SHORT: mux_decode = {3'h5, 3'h5}; // RL14
            default: mux_decode = {3'h0, 3'h1};
        endcase
    endfunction

    always_comb begin
        setup_d = setup_q;
        restart_d = 1'b0;
        // Only the setup address is writable; status writes fall away
        if (cmd.write_req && cmd.addr == `ADCCS_ADDR_SETUP) begin // RL6 RL17
            setup_d = cmd.wdata;
            restart_d = 1'b1; // RL16
        end
        // Set wins over the read-clear so no result is lost
        flag_d = flag_q;
        if (data_read) begin
            flag_d = 1'b0; // RL9
        end
        if (result_done) begin
            flag_d = 1'b1; // RL8
        end
        rdata_d = rdata_q;
        if (cmd.read_req) begin
            if (cmd.addr == `ADCCS_ADDR_STATUS) begin
                rdata_d = {flag_q, `ADCCS_STATUS_RSVD}; // RL7 RL10
            end else begin
                rdata_d = setup_q; // RL15
            end
        end
        {ctrl_d.positive_converter_input, ctrl_d.negative_converter_input} =
            mux_decode(adccs_mux_t'(setup_d[`ADCCS_MUX_HI:`ADCCS_MUX_LO]));
        ctrl_d.gain_four = setup_d[`ADCCS_GAIN_BIT]; // RL2
        ctrl_d.sample_rate_select = adccs_rate_t'(
            setup_d[`ADCCS_RATE_HI:`ADCCS_RATE_LO]); // RL3
        ctrl_d.continuous = setup_d[`ADCCS_MODE_BIT]; // RL4
        ctrl_d.use_ext_ref = setup_d[`ADCCS_REF_BIT]; // RL5
    end

    // Power-down does not touch these flops, so values are retained
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            setup_q <= `ADCCS_SETUP_RESET; // RL6
            flag_q <= 1'b0; // RL7
            rdata_q <= 8'h00;
            restart_q <= 1'b0;
            ctrl_q <= adccs_ctrl_t'({3'h0, 3'h1, 1'b0, ADCCS_RATE_20,
                1'b0, 1'b0});
            pin_level_q <= 1'b0; // RL13
            scl_drive_q <= 1'b0; // RL11
        end else begin
            pin_level_q <= 1'b0; // RL13
            scl_drive_q <= 1'b0; // RL11
            setup_q <= setup_d;
            flag_q <= flag_d;
            rdata_q <= rdata_d;
            restart_q <= restart_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl = ctrl_q;
    assign rdata = rdata_q;
    assign filter_restart = restart_q;
    assign ready_pin_out = pin_level_q; // RL13
    assign ready_pin_oe = flag_q; // RL13
    assign scl_oe = scl_drive_q; // RL11 RL12
endmodule // adccs_regs
`default_nettype wire

// ### logic/adccs_cfg.svh
// Register map constants for the converter setup and status registers
// Overview of operation
// RL1: Bits 7:5 choose differential or single-ended pair
// RL2: Bit 4 selects gain one or four
// RL3: Bits 3:2 select 20/90/330/1000 samples per second
// RL4: Bit 1 clear single-shot, set continuous
// RL5: Bit 0 selects internal or external reference
// RL6: Setup register read-write, cleared on reset
// RL7: Status at address 1, read-only, flag resets
// RL8: Status bit 7 set on new result
// RL9: Reading conversion data clears ready flag
// RL10: Host ignores status bits 6:0
// RL11: Serial clock line is never held low
// RL12: Works with standard, fast, fast-plus controllers
// RL13: Ready pin open-drain, only pulls low
// RL14: Code 111 shorts inputs to mid-supply
// RL15: Registers reached by commands, kept in power-down
// RL16: Setup write resets filter, restarts conversion
// RL17: Writes to status register are ignored
`ifndef ADCCS_CFG_SVH
`define ADCCS_CFG_SVH
`define ADCCS_ADDR_SETUP 1'h0
`define ADCCS_ADDR_STATUS 1'h1
`define ADCCS_SETUP_RESET 8'h00
`define ADCCS_MUX_HI 7
`define ADCCS_MUX_LO 5
`define ADCCS_GAIN_BIT 4
`define ADCCS_RATE_HI 3
`define ADCCS_RATE_LO 2
`define ADCCS_MODE_BIT 1
`define ADCCS_REF_BIT 0
`define ADCCS_STATUS_RSVD 7'h00
`endif

// ### logic/adccs_pkg.sv
// Types for the converter setup and status registers
`default_nettype none
package adccs_pkg;
    typedef enum logic [1:0] {
        ADCCS_RATE_20, ADCCS_RATE_90, ADCCS_RATE_330, ADCCS_RATE_1000
    } adccs_rate_t;
    typedef enum logic [2:0] {
        ADCCS_IN_0_1, ADCCS_IN_2_3, ADCCS_IN_1_2, ADCCS_IN_0_GND,
        ADCCS_IN_1_GND, ADCCS_IN_2_GND, ADCCS_IN_3_GND, ADCCS_IN_MID_SHORT
    } adccs_mux_t;
    // Decoded analog steering: input indices 0..3, 4 ground, 5 mid-supply
    typedef struct packed {
        logic [2:0] positive_converter_input;
        logic [2:0] negative_converter_input;
        logic gain_four;
        adccs_rate_t sample_rate_select;
        logic continuous;
        logic use_ext_ref;
    } adccs_ctrl_t;
    typedef struct packed {
        logic write_req;
        logic read_req;
        logic addr;
        logic [7:0] wdata;
    } adccs_cmd_t;
endpackage : adccs_pkg
`default_nettype wire

// ### verif/adccs_regs_asserts.sv
// Port checker for the converter register pair
`default_nettype none
module adccs_regs_asserts import adccs_pkg::*; (
    // Clock, reset and inputs
    input wire logic sys_clk, rst, data_read, result_done,
    input wire adccs_cmd_t cmd,
    // Outputs
    input wire adccs_ctrl_t ctrl,
    input wire logic [7:0] rdata,
    input wire logic filter_restart, ready_pin_out, ready_pin_oe, scl_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic wr0 = cmd.write_req && !cmd.addr;
    a_no_stretch: assert property (!scl_oe) else $error("scl");
    a_pin_low: assert property (!ready_pin_out) else $error("pin");
    a_restart_pulse: assert property (wr0 |=> filter_restart)
        else $error("restart");
    a_status_ignored: assert property (cmd.write_req && cmd.addr
        |=> !filter_restart) else $error("status write");
    a_flag_set: assert property (result_done |=> ready_pin_oe)
        else $error("flag set");
    a_flag_clear: assert property (data_read && !result_done
        |=> !ready_pin_oe) else $error("flag clear");
    a_setup_fields: assert property (wr0
        |=> ctrl[4:0] == $past(cmd.wdata[4:0])) else $error("fields");
    a_status_read: assert property (cmd.read_req && cmd.addr
        |=> rdata == {$past(ready_pin_oe), 7'h00}) else $error("status");
    a_reset_vals: assert property (disable iff (1'b0) $fell(rst)
        |-> rdata == 8'h00 && !ready_pin_oe && ctrl[4:0] == 5'h00)
        else $error("reset");
    c_flag: cover property (result_done);
    c_clear: cover property (data_read && ready_pin_oe);
    c_ignored: cover property (cmd.write_req && cmd.addr);
endmodule // adccs_regs_asserts
bind adccs_regs adccs_regs_asserts adccs_regs_asserts_i(.sys_clk, .rst,
    .data_read, .result_done, .cmd, .ctrl, .rdata, .filter_restart,
    .ready_pin_out, .ready_pin_oe, .scl_oe);
`default_nettype wire

// ### verif/adccs_host.sv
// Host command source for the register pair
`default_nettype none
module adccs_host import adccs_pkg::*; (
    input wire logic sys_clk,
    output var adccs_cmd_t cmd
);
    timeunit 1ns; timeprecision 1ns;
    initial cmd = '0;
    // Idle data is inverted so stale bytes cannot pass for fresh ones
    task automatic op(input logic w, a, input logic [7:0] d);
        @(negedge sys_clk) cmd = '{w, !w, a, d};
        @(negedge sys_clk) cmd = '{1'b0, 1'b0, !a, ~d};
    endtask
endmodule // adccs_host
`default_nettype wire

// ### verif/adc_config_status_regs_test.sv
// Random self-checking bench for the converter register pair
`default_nettype none
module adc_config_status_regs_test import adccs_pkg::*; ;
    timeunit 1ns; timeprecision 1ns;
    logic sys_clk = 0, rst = 1, data_read = 0, result_done = 0, flag = 0;
    logic filter_restart, ready_pin_out, ready_pin_oe, scl_oe;
    logic [7:0] rdata, s;
    logic [7:0] pn[8] = '{8'h01, 8'h23, 8'h12, 8'h04, 8'h14, 8'h24, 8'h34,
        8'h55};
    adccs_cmd_t cmd;
    adccs_ctrl_t ctrl;
    int mismatches = 0, n_tests = 0;
    always #10 sys_clk = ~sys_clk;
    adccs_host adccs_host_i(.sys_clk, .cmd);
    adccs_regs adccs_regs_i(.sys_clk, .rst, .cmd, .data_read, .result_done,
        .ctrl, .rdata, .filter_restart, .ready_pin_out, .ready_pin_oe,
        .scl_oe);
    function automatic logic [12:0] exp_ctl(logic [7:0] v);
        return {pn[v[7:5]][6:4], pn[v[7:5]][2:0], v[4:0]};
    endfunction
    task automatic chk(logic [12:0] g, e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #50us;
        mismatches++;
        wrap_up();
    end
    initial begin
        void'($urandom(99));
        repeat (2) @(negedge sys_clk);
        rst = 0;
        adccs_host_i.op(0, 1, 8'h00);
        chk(rdata, 13'h0);
        for (int i = 0; i < 32; i++) begin
            s = 8'($urandom);
            if (i < 8) s[7:5] = i[2:0];
            adccs_host_i.op(1, 0, s);
            chk(ctrl, exp_ctl(s));
            chk(filter_restart, 13'h1);
            adccs_host_i.op(0, 0, 8'h00);
            chk(rdata, s);
            {result_done, data_read} = 2'($urandom);
            flag = result_done | (flag & !data_read);
            @(negedge sys_clk) {result_done, data_read} = 2'h0;
            chk(ready_pin_oe, flag);
            adccs_host_i.op(1, 1, 8'($urandom));
            adccs_host_i.op(0, 1, 8'h00);
            chk(rdata, {flag, 7'h00});
        end
        wrap_up();
    end
endmodule // adc_config_status_regs_test
`default_nettype wire
